// ### design/adc_config_override_defs.svh
// Register offsets, field positions, reset values and timing counts of the config bank.
`ifndef ADC_CONFIG_OVERRIDE_DEFS_SVH
`define ADC_CONFIG_OVERRIDE_DEFS_SVH

// Serial port frame layout: 16 instruction bits then 8 data bits.
`define SER_ADDR_W 13
`define SER_INSTR_BITS 5'h10
`define SER_FRAME_BITS 5'h18
`define SER_RW_BIT 15

// Register offsets on the serial port.
`define POWER_MODE_ADDR 13'h008
`define TRANSFER_ADDR 13'h0ff
`define OVERRIDE_ADDR 13'h100
`define PULLDOWN_CTRL_ADDR 13'h101
`define BIAS_GEN_CTRL_ADDR 13'h102

// Field positions.
`define PWR_MODE_LSB 0
`define PWR_PIN_FUNC_BIT 5
`define TRANSFER_BIT 0
`define OVR_RATE_LSB 0
`define OVR_ENABLE_BIT 3
`define OVR_RES_LSB 4
`define PULLDOWN_DIS_BIT 0
`define CM_GEN_PD_BIT 3

// Reset values.
`define POWER_MODE_RST 8'h00
`define OVERRIDE_RST 8'h00
`define PULLDOWN_CTRL_RST 8'h00
`define BIAS_GEN_CTRL_RST 8'h00

// Initialisation phase timing.
`define REF_CLK_PERIOD_NS 10
`define INIT_PHASE_TIME_NS 1000
`define INIT_PHASE_CYCLES ((`INIT_PHASE_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

// ### design/adc_config_override_pkg.sv
// Types shared by the converter configuration bank.
package adc_config_override_pkg;

	// Initialisation sequencer states, Gray coded along the bias, regs, run, hold loop.
	typedef enum logic [1:0] {
		INIT_BIAS = 2'h0,
		INIT_REGS = 2'h1,
		RUN = 2'h3,
		HOLD = 2'h2
	} init_state_t;

	// Internal power-down modes of the power-mode field.
	typedef enum logic [1:0] {
		PWR_NORMAL = 2'h0,
		PWR_DOWN = 2'h1,
		PWR_STANDBY = 2'h2,
		PWR_DIG_RESET = 2'h3
	} pwr_mode_t;

endpackage

// ### design/adc_config_override_regs.sv
// Serial-port configuration bank with rate override, pull-down, bias and init control.
//
// Behaviour
// (R1) Override accepts only downgrades of the grade.
// (R2) Upgrade attempt powers down the whole chip.
// (R3) Override takes effect only on transfer strobe.
// (R4) Pull-down control bit 0 disables pin pull-down.
// (R5) Bias control bit 3 powers down generator.
// (R6) Power-up initialisation sequence runs on sample clock.
// (R7) Host writes 03 then 00 to re-initialise.
// (R8) Host repeats reset after unstable external reference.
// (R9) Host keeps serial port idle during sampling.
// (R10) Mode 11 resets datapath; 00 restores it.
// (R11) Other registers update at once when written.
// (R12) Transfer bit pulses once and reads zero.
`timescale 1ns/10ps
`include "adc_config_override_defs.svh"

module adc_config_override_regs #(
	parameter logic [2:0] DEFAULT_RATE_CODE = 3'h7, // Factory speed grade code.
	parameter int INIT_CYCLES = `INIT_PHASE_CYCLES // Cycles per init phase.
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	output logic sdio_pulldown_en,
	output logic common_mode_generator_pd,
	output logic chip_powerdown,
	output logic datapath_reset,
	output logic datapath_clk_en,
	output logic outputs_en,
	output logic pdwn_pin_standby,
	output logic init_done,
	output logic [2:0] rate_code,
	output logic [1:0] resolution_code
);

	// Read multiplexer for the serial read path.
	function automatic logic [7:0] reg_read(input logic [12:0] a, input logic [7:0] pm,
		input logic [7:0] ov, input logic [7:0] pd, input logic [7:0] bg);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			`POWER_MODE_ADDR: d = pm;
			`OVERRIDE_ADDR: d = ov;
			`PULLDOWN_CTRL_ADDR: d = pd;
			`BIAS_GEN_CTRL_ADDR: d = bg;
			default: d = 8'h00; // Transfer and unmapped offsets read zero.
		endcase
		return d;
	endfunction

	// Two-stage synchronisers for the asynchronous port pins, plus an edge stage.
	logic [2:0] sclk_s_r;
	logic [1:0] sel_s_r;
	logic [1:0] din_s_r;

	// Serial shifter state.
	logic [4:0] bit_cnt_r;
	logic [15:0] instr_r;
	logic [6:0] data_sr_r;
	logic [7:0] rd_sr_r;
	logic oe_r;

	// Register storage.
	logic [7:0] pwr_mode_r;
	logic [7:0] ovr_shadow_r; // Host-visible override value.
	logic [7:0] ovr_active_r; // Value the converter actually uses.
	logic [7:0] pulldown_r;
	logic [7:0] bias_gen_r;
	logic xfer_stb_r;

	// Init sequencer.
	adc_config_override_pkg::init_state_t init_state_r;
	adc_config_override_pkg::init_state_t init_state_nxt;
	logic [15:0] init_cnt_r;

	// Registered outputs.
	logic chip_pd_r;
	logic dp_reset_r;
	logic dp_clk_en_r;
	logic outputs_en_r;

	// Port edge decode; the second synchroniser stage is read here, and the edge stage as well for the serial clock.
	wire sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
	wire sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
	wire selected = ~sel_s_r[1];
	wire [12:0] addr = instr_r[12:0];
	wire is_read = instr_r[`SER_RW_BIT];
	wire wr_go = ce & selected & sclk_rise & ~is_read & (bit_cnt_r == `SER_FRAME_BITS - 5'h01);
	wire [7:0] wr_data = {data_sr_r, din_s_r[1]};
	wire wr_pwr = wr_go & (addr == `POWER_MODE_ADDR);
	wire wr_xfer = wr_go & (addr == `TRANSFER_ADDR) & wr_data[`TRANSFER_BIT];
	wire wr_ovr = wr_go & (addr == `OVERRIDE_ADDR);
	wire wr_pd = wr_go & (addr == `PULLDOWN_CTRL_ADDR);
	wire wr_bg = wr_go & (addr == `BIAS_GEN_CTRL_ADDR);
	wire [7:0] rd_data = reg_read(addr, pwr_mode_r, ovr_shadow_r, pulldown_r, bias_gen_r);

	// Decoded power mode and override fields.
	wire [1:0] pmode = pwr_mode_r[`PWR_MODE_LSB +: 2];
	wire dig_reset = pmode == adc_config_override_pkg::PWR_DIG_RESET;
	wire normal = pmode == adc_config_override_pkg::PWR_NORMAL;
	wire ovr_en = ovr_active_r[`OVR_ENABLE_BIT];
	wire [2:0] ovr_rate = ovr_active_r[`OVR_RATE_LSB +: 3];
	wire ovr_upgrade = ovr_en & (ovr_rate > DEFAULT_RATE_CODE); // see R2
	wire init_phase_end = init_cnt_r == 16'(INIT_CYCLES - 1);

	// Synchronisers freeze with the clock enable as well, so a pin edge that arrives
	// while the bank is frozen is seen once it runs only if the pin still holds its new level.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclk_s_r <= 3'h0;
			sel_s_r <= 2'h3;
			din_s_r <= 2'h0;
		end else if (ce) begin
			sclk_s_r <= {sclk_s_r[1:0], sclk};
			sel_s_r <= {sel_s_r[0], serial_select_n};
			din_s_r <= {din_s_r[0], sdio_in};
		end
	end

	// Serial shifter: sample on rising clock, drive read data from the falling clock.
	// The port stays alive in every power mode so the host can always recover the part.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_cnt_r <= 5'h00;
			instr_r <= 16'h0000;
			data_sr_r <= 7'h00;
			rd_sr_r <= 8'h00;
			oe_r <= 1'b0;
		end else if (ce) begin
			if (!selected) begin
				bit_cnt_r <= 5'h00;
				oe_r <= 1'b0;
			end else if (sclk_rise) begin
				if (bit_cnt_r < `SER_INSTR_BITS) begin
					instr_r <= {instr_r[14:0], din_s_r[1]};
				end else begin
					data_sr_r <= wr_data[6:0];
				end
				if (bit_cnt_r != `SER_FRAME_BITS) begin
					bit_cnt_r <= bit_cnt_r + 5'h01;
				end
			end else if (sclk_fall && is_read && bit_cnt_r == `SER_INSTR_BITS) begin
				rd_sr_r <= rd_data;
				oe_r <= 1'b1;
			end else if (sclk_fall && oe_r) begin
				rd_sr_r <= {rd_sr_r[6:0], 1'b0};
			end
		end
	end

	// Register writes. Everything but the override goes live at once.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pwr_mode_r <= `POWER_MODE_RST;
			ovr_shadow_r <= `OVERRIDE_RST;
			ovr_active_r <= `OVERRIDE_RST;
			pulldown_r <= `PULLDOWN_CTRL_RST;
			bias_gen_r <= `BIAS_GEN_CTRL_RST;
			xfer_stb_r <= 1'b0;
		end else if (ce) begin
			if (wr_pwr) begin
				pwr_mode_r <= wr_data; // see R11
			end
			if (wr_pd) begin
				pulldown_r <= wr_data; // see R11
			end
			if (wr_bg) begin
				bias_gen_r <= wr_data; // see R11
			end
			if (wr_ovr) begin
				ovr_shadow_r <= wr_data; // see R3
			end
			// The transfer bit is never stored, so it reads back zero.
			xfer_stb_r <= wr_xfer; // see R12
			if (xfer_stb_r) begin
				ovr_active_r <= ovr_shadow_r; // see R3
			end
		end
	end

	// Init sequencer next state; a digital reset parks it in hold until mode 00.
	always_comb begin
		init_state_nxt = init_state_r;
		unique case (init_state_r)
			adc_config_override_pkg::INIT_BIAS:
				if (init_phase_end) init_state_nxt = adc_config_override_pkg::INIT_REGS;
			adc_config_override_pkg::INIT_REGS:
				if (init_phase_end) init_state_nxt = adc_config_override_pkg::RUN;
			adc_config_override_pkg::RUN:
				if (dig_reset) init_state_nxt = adc_config_override_pkg::HOLD; // see R10
			adc_config_override_pkg::HOLD:
				if (normal) init_state_nxt = adc_config_override_pkg::INIT_BIAS; // see R7
		endcase
		if (dig_reset) begin
			init_state_nxt = adc_config_override_pkg::HOLD; // see R10
		end
	end

	// Sequencer state, phase counter and the registered control outputs.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			init_state_r <= adc_config_override_pkg::INIT_BIAS;
			init_cnt_r <= 16'h0000;
			chip_pd_r <= 1'b0;
			dp_reset_r <= 1'b1;
			dp_clk_en_r <= 1'b0;
			outputs_en_r <= 1'b0;
		end else if (ce) begin
			init_state_r <= init_state_nxt; // see R6
			// The counter restarts at each phase change so both phases last equally.
			if (init_state_nxt != init_state_r || init_state_r == adc_config_override_pkg::RUN) begin
				init_cnt_r <= 16'h0000;
			end else begin
				init_cnt_r <= init_cnt_r + 16'h0001;
			end
			chip_pd_r <= ovr_upgrade; // see R2
			dp_reset_r <= dig_reset || init_state_nxt != adc_config_override_pkg::RUN; // see R10
			dp_clk_en_r <= normal && init_state_nxt == adc_config_override_pkg::RUN && !ovr_upgrade;
			outputs_en_r <= normal && init_state_nxt == adc_config_override_pkg::RUN && !ovr_upgrade;
		end
	end

	// Output drive. The effective rate never exceeds the factory grade.
	assign sdio_out = rd_sr_r[7];
	assign sdio_oe = oe_r;
	assign sdio_pulldown_en = ~pulldown_r[`PULLDOWN_DIS_BIT]; // see R4
	assign common_mode_generator_pd = bias_gen_r[`CM_GEN_PD_BIT]; // see R5
	assign chip_powerdown = chip_pd_r;
	assign datapath_reset = dp_reset_r;
	assign datapath_clk_en = dp_clk_en_r;
	assign outputs_en = outputs_en_r;
	assign pdwn_pin_standby = pwr_mode_r[`PWR_PIN_FUNC_BIT];
	assign init_done = init_state_r == adc_config_override_pkg::RUN;
	assign rate_code = (ovr_en && !ovr_upgrade) ? ovr_rate : DEFAULT_RATE_CODE; // see R1
	assign resolution_code = ovr_en ? ovr_active_r[`OVR_RES_LSB +: 2] : 2'h0;

	// Checks on the bank's own behaviour.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	rate_downgrade_a: assert property (rate_code <= DEFAULT_RATE_CODE) // see R1
		else $error("Effective rate exceeds factory grade.");
	upgrade_pd_a: assert property (ce && ovr_upgrade |=> chip_powerdown) // see R2
		else $error("Upgrade attempt did not power down.");
	override_hold_a: assert property (!xfer_stb_r |=> $stable(ovr_active_r)) // see R3
		else $error("Override changed without transfer.");
	xfer_load_a: assert property (ce && xfer_stb_r |=> ovr_active_r == $past(ovr_shadow_r)) // see R3
		else $error("Transfer did not load override.");
	xfer_pulse_a: assert property (ce && xfer_stb_r |=> !xfer_stb_r) // see R12
		else $error("Transfer strobe longer than one cycle.");
	pulldown_write_a: assert property (wr_pd |=> sdio_pulldown_en == !$past(wr_data[0])) // see R4
		else $error("Pull-down control not applied.");
	cm_gen_write_a: assert property (wr_bg |=> common_mode_generator_pd == $past(wr_data[3])) // see R5
		else $error("Generator power-down not applied.");
	dig_reset_a: assert property (ce && dig_reset |=> datapath_reset && !outputs_en) // see R10
		else $error("Digital reset did not stop datapath.");
	init_run_a: assert property (ce && init_state_r == adc_config_override_pkg::HOLD && normal // see R6
		|=> init_state_r == adc_config_override_pkg::INIT_BIAS ##1 !init_done)
		else $error("Init did not restart after reset.");

	write_seen_c: cover property (wr_go);
	transfer_c: cover property (xfer_stb_r ##1 ovr_en);
	reinit_c: cover property (init_state_r == adc_config_override_pkg::HOLD ##[1:20] init_done);
	read_c: cover property (oe_r);

endmodule // adc_config_override_regs

// ### sim/adc_host_model.sv
// Host controller model that runs framed transfers on the serial control port.
`timescale 1ns/10ps

module adc_host_model (
	input wire logic ref_clk,
	input wire logic sdio_out,
	input wire logic sdio_oe,
	input wire logic sdio_pulldown_en,
	output logic sclk,
	output logic serial_select_n,
	output wire logic sdio_in,
	output logic [7:0] rd_byte,
	output logic rd_valid
);
	logic h_oe; // High while the host drives the data line.
	logic h_bit; // Bit the host puts on the data line.

	// A released line without its pull-down shows the inverse of the last bit, never a held value.
	assign sdio_in = sdio_oe ? sdio_out : (h_oe ? h_bit : (sdio_pulldown_en ? 1'b0 : ~h_bit));

	// The port starts idle, with the select high and the clock standing low.
	initial begin
		sclk = 1'b0;
		serial_select_n = 1'b1;
		h_oe = 1'b0;
		h_bit = 1'b0;
		rd_byte = 8'h00;
		rd_valid = 1'b0;
	end

	// Six sample clocks per half period keep the serial clock well below its speed limit.
	task automatic half();
		repeat (6) @(negedge ref_clk);
	endtask

	// One whole frame; bits change while the clock is low, reads release the line for the data.
	task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] data);
		logic [23:0] frame;
		frame = {rd, 2'h0, addr, data};
		serial_select_n = 1'b0;
		h_oe = 1'b1;
		for (int i = 23; i >= 0; i--) begin
			h_bit = frame[i];
			h_oe = !(rd && i < 8);
			half();
			sclk = 1'b1;
			rd_byte[i % 8] = sdio_in;
			half();
			sclk = 1'b0;
		end
		h_oe = 1'b0;
		serial_select_n = 1'b1;
		rd_valid = rd;
		half();
		rd_valid = 1'b0;
	endtask

	// Digital reset: the power mode goes to 03 and back to 00, which reruns initialisation.
	task automatic dig_reset();
		xfer(1'b0, 13'h008, 8'h03);
		xfer(1'b0, 13'h008, 8'h00);
	endtask
endmodule // adc_host_model

// ### sim/tb_adc_config_override_regs.sv
// Self-checking bench for the converter configuration bank.
`timescale 1ns/10ps

module tb_adc_config_override_regs;
	logic ref_clk, rst, ce, sclk, serial_select_n, sdio_out, sdio_oe, sdio_pulldown_en;
	logic common_mode_generator_pd, chip_powerdown, datapath_reset, datapath_clk_en;
	logic outputs_en, pdwn_pin_standby, init_done, rd_valid;
	wire sdio_in;
	logic [2:0] rate_code;
	logic [1:0] resolution_code;
	logic [7:0] rd_byte;
	logic [20:0] notes[$]; // Expected byte, flags, rate, enables, pin mode, resolution.
	int fail_count, compares;
	logic [2:0] r; // Random rate code chosen for the override tests.
	logic [1:0] q; // Random resolution code chosen for the transfer test.

	// A smaller default grade leaves room for both downgrades and upgrades.
	adc_config_override_regs #(.DEFAULT_RATE_CODE(3'h5), .INIT_CYCLES(4))
		i_adc_config_override_regs (
		.ref_clk(ref_clk), .rst(rst), .ce(ce), .sclk(sclk), .serial_select_n(serial_select_n),
		.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.sdio_pulldown_en(sdio_pulldown_en), .common_mode_generator_pd(common_mode_generator_pd),
		.chip_powerdown(chip_powerdown), .datapath_reset(datapath_reset),
		.datapath_clk_en(datapath_clk_en), .outputs_en(outputs_en),
		.pdwn_pin_standby(pdwn_pin_standby), .init_done(init_done), .rate_code(rate_code),
		.resolution_code(resolution_code));

	adc_host_model i_adc_host_model (.ref_clk(ref_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.sdio_pulldown_en(sdio_pulldown_en), .sclk(sclk), .serial_select_n(serial_select_n),
		.sdio_in(sdio_in), .rd_byte(rd_byte), .rd_valid(rd_valid));

	// The sample clock runs at 100 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Each read result is compared with the oldest note; a missing note is a mismatch too.
	always @(posedge rd_valid) begin
		compares++;
		if (notes.size() == 0 || {rd_byte, sdio_pulldown_en, common_mode_generator_pd,
			chip_powerdown, datapath_reset, init_done, rate_code, datapath_clk_en, outputs_en,
			pdwn_pin_standby, resolution_code} !== notes.pop_front()) begin
			fail_count++;
			$display("BAD %0t read or status mismatch", $time);
		end
	end

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		i_adc_host_model.xfer(1'b0, a, d);
	endtask

	// Flags are pull-down, generator down, chip down, datapath reset and init done; the last
	// group is datapath clocks, outputs, pin standby function and the resolution code.
	task automatic chk(input logic [12:0] a, input logic [7:0] d, input logic [4:0] f,
		input logic [2:0] rc, input logic [4:0] o);
		notes.push_back({d, f, rc, o});
		i_adc_host_model.xfer(1'b1, a, 8'h00);
	endtask

	// Initialisation ends within a bounded number of cycles.
	task automatic wait_init();
		for (int i = 0; i < 60 && init_done !== 1'b1; i++) @(negedge ref_clk);
		// Running out of the limit is a mismatch, not a silent pass.
		if (init_done !== 1'b1) begin
			fail_count++;
			$display("BAD %0t initialisation did not finish", $time);
		end
	endtask

	task automatic end_sim();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// The whole run needs about 80 us, so a hang is cut off well past that.
	initial begin
		#300000;
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		end_sim();
	end

	// Main sequence: reset, then one block of traffic per feature.
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		void'($urandom(79));
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		wait_init();
		chk(13'h101, 8'h00, 5'h11, 3'h5, 5'h18);
		chk(13'h055, 8'h00, 5'h11, 3'h5, 5'h18);
		$display("test 1 done");
		wr(13'h101, 8'h01);
		chk(13'h101, 8'h01, 5'h01, 3'h5, 5'h18);
		wr(13'h101, 8'h00);
		chk(13'h101, 8'h00, 5'h11, 3'h5, 5'h18);
		$display("test 2 done");
		wr(13'h102, 8'h08);
		chk(13'h102, 8'h08, 5'h19, 3'h5, 5'h18);
		wr(13'h102, 8'h00);
		$display("test 3 done");
		// Standby with the pin function bit: clocks and outputs stop, no reinitialisation.
		wr(13'h008, 8'h22);
		chk(13'h008, 8'h22, 5'h11, 3'h5, 5'h04);
		wr(13'h008, 8'h00);
		wr(13'h008, 8'h03);
		chk(13'h008, 8'h03, 5'h12, 3'h5, 5'h00);
		wr(13'h008, 8'h00);
		wait_init();
		chk(13'h008, 8'h00, 5'h11, 3'h5, 5'h18);
		i_adc_host_model.dig_reset();
		wait_init();
		chk(13'h008, 8'h00, 5'h11, 3'h5, 5'h18);
		$display("test 4 done");
		r = 3'($urandom % 5);
		q = 2'($urandom);
		wr(13'h100, {2'h0, q, 1'b1, r});
		chk(13'h100, {2'h0, q, 1'b1, r}, 5'h11, 3'h5, 5'h18);
		wr(13'h0ff, 8'h01);
		chk(13'h0ff, 8'h00, 5'h11, r, {3'h6, q});
		$display("test 5 done");
		r = 3'(6 + $urandom % 2);
		wr(13'h100, {5'h01, r});
		wr(13'h0ff, 8'h01);
		chk(13'h0ff, 8'h00, 5'h15, 3'h5, 5'h00);
		$display("test 6 done");
		end_sim();
	end
endmodule // tb_adc_config_override_regs
